/* dacc_pkg.sv */
// package: constants and carrier types for the decimal accumulator
package dacc_pkg;

  // ==========================================================
  // machine cycle geometry (one clock edge = one degree)
  // ==========================================================
  localparam int          ANGLE_W        = 9;                 // counter width
  localparam logic [8:0]  ANGLE_LAST     = 9'h167;            // 359 degrees
  localparam logic [8:0]  SENSE_FIRST    = 9'h009;            // digit 9 sensed at 9
  localparam logic [8:0]  SENSE_LAST     = 9'h099;            // digit 1 sensed at 153
  localparam logic [8:0]  DEG_PER_UNIT   = 9'h012;            // 18 degrees per unit
  localparam logic [3:0]  ENGAGE_DLY     = 4'hc;              // 12 degrees to mesh
  localparam logic [8:0]  ADD_STOP       = 9'h0b7;            // first stop point, 183
  localparam logic [8:0]  CARRY_WIN_OPEN = 9'h0db;            // carry window closes at 219
  localparam logic [8:0]  CARRY_WIN_END  = 9'h0e7;            // window released at 231
  localparam logic [8:0]  CARRY_PULSE    = 9'h0e1;            // carry pulse at 225
  localparam logic [8:0]  CARRY_STOP     = 9'h0ff;            // second stop point, 255
  localparam logic [8:0]  PEND_CLEAR     = 9'h100;            // pending cleared at 256

  // ==========================================================
  // position layout
  // ==========================================================
  localparam int          NUM_POS        = 80;                // positions fitted
  localparam int          NUM_GROUPS     = 16;                // four each of 2,4,6,8
  localparam logic [3:0]  DIGIT_NINE     = 4'h9;              // top decimal value
  localparam logic [4:0]  SUB_LAST       = 5'h11;             // 17: last degree of a unit

  // per-position wheel state
  typedef struct packed {
    logic [3:0] digit;       // value standing on the wheel
    logic       engaged;     // clutch in mesh, wheel turning
    logic [3:0] dly;         // degrees left before mesh
    logic [4:0] sub;         // degrees turned within current unit
    logic       pending;     // carry pending (wheel passed 9 to 0)
    logic       add_done;    // add start already taken this cycle
    logic       carry_done;  // carry start already taken this cycle
  } pos_state_t;

  // timing contacts derived from the angle
  typedef struct packed {
    logic cycle_timing;      // digit sensing contact
    logic carry_window;      // carry window contact
  } contacts_t;

endpackage : dacc_pkg

/* decimal_accumulator_add_carry.sv */
// decimal accumulator: per-position add wheels with parallel carry
//
// Summary of operation
// RULE1: digit n sensed at 9+18*(9-n) degrees
// RULE2: wheel meshes exactly 12 degrees after start
// RULE3: add advance stops and disengages at 183
// RULE4: one decimal unit per 18 degrees turned
// RULE5: disengaged wheel holds its digit fixed
// RULE6: each position wraps modulo ten
// RULE7: wrap 9 to 0 latches carry pending
// RULE8: carry pulse 225, window contact, pending gated
// RULE9: carry starts next position, one unit
// RULE10: second stop point ends carry advance
// RULE11: pending flags cleared at 256 degrees
// RULE12: per-position nine indication output
// RULE13: carry through nines passed in parallel
// RULE14: groups 2,4,6,8 by four; carry stays inside
// RULE15: angle counter 0 to 359 drives everything
// RULE16: one add and one carry per cycle
`timescale 1ns/1ps
module decimal_accumulator_add_carry #(
  parameter int NPOS = dacc_pkg::NUM_POS                      // positions fitted
) (
  // clock and reset
  input  wire  logic                           sys_clk_i,
  input  wire  logic                           rstn_i,
  // reading brushes, one per position, high while contact through a hole
  input  wire  logic [NPOS-1:0]                hole_i,
  // machine timing
  output logic [dacc_pkg::ANGLE_W-1:0]         angle_o,
  output logic                                 cycle_timing_contact_o,
  output logic                                 carry_window_contact_o,
  // accumulator state
  output logic [NPOS-1:0][3:0]                 digit_o,
  output logic [NPOS-1:0]                      nine_o,
  output logic [NPOS-1:0]                      carry_pending_o,
  output logic [NPOS-1:0]                      engaged_o
);
  import dacc_pkg::*;

  // ==========================================================
  // helpers
  // ==========================================================
  // true at the digit sensing angles 9,27,...,153
  function automatic logic sense_angle(input logic [8:0] a);
    logic [8:0] off;
    off = a - SENSE_FIRST;
    return (a >= SENSE_FIRST) && (a <= SENSE_LAST) && ((off % DEG_PER_UNIT) == 9'h000);
  endfunction : sense_angle

  // true when position i is the high-order end of its group
  function automatic logic group_top(input int i);
    int base;
    logic top;
    base = 0;
    top  = 1'b0;
    for (int g = 0; g < NUM_GROUPS; g++)
    begin
      base = base + 2 * (g / 4 + 1);
      if (i == base - 1)
        top = 1'b1;
    end
    return top;
  endfunction : group_top

  // ==========================================================
  // cycle angle counter and contacts
  // ==========================================================
  logic [8:0] angle_r;             // present cycle angle
  logic [8:0] angle_nxt;           // next cycle angle
  contacts_t  cont_r;              // contacts as seen at angle_r
  contacts_t  cont_nxt;            // contacts for angle_nxt

  // advance one degree per edge, wrap at 359
  always_comb
  begin
    angle_nxt = (angle_r == ANGLE_LAST) ? 9'h000 : angle_r + 9'h001;                 // [RULE15]
    cont_nxt.cycle_timing = sense_angle(angle_nxt);                                   // [RULE1]
    cont_nxt.carry_window = (angle_nxt >= CARRY_WIN_OPEN) && (angle_nxt < CARRY_WIN_END); // [RULE8]
  end

  // register angle and contacts together so they stay aligned
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      angle_r <= 9'h000;
      cont_r  <= '0;
    end
    else
    begin
      angle_r <= angle_nxt;
      cont_r  <= cont_nxt;
    end
  end

  // ==========================================================
  // start pulses: add from brushes, carry chained within groups
  // ==========================================================
  pos_state_t            pos_r   [NPOS];   // wheel state
  pos_state_t            pos_nxt [NPOS];   // next wheel state
  logic       [NPOS-1:0] add_fire;         // add start taken now
  logic       [NPOS-1:0] carry_in;         // carry start arriving now
  logic       [NPOS-1:0] nine_r;           // registered nine indication
  logic       [NPOS-1:0] nine_nxt;         // next nine indication
  logic                  carry_pulse;      // qualified carry impulse

  // carry is only issued at 225 and only while the window contact is closed
  assign carry_pulse = cont_r.carry_window && (angle_r == CARRY_PULSE);               // [RULE8]

  // chain evaluated combinationally so every affected wheel starts together;
  // a long run of nines costs only gate depth, never extra degrees
  always_comb
  begin
    for (int i = 0; i < NPOS; i++)
    begin
      // brush gated by sensing contact; ignored if already started
      add_fire[i] = hole_i[i] && cont_r.cycle_timing && !pos_r[i].add_done
                    && !pos_r[i].engaged && (pos_r[i].dly == 4'h0);                   // [RULE16]
      if (i == 0 || group_top(i - 1))
        carry_in[i] = 1'b0;                                                           // [RULE14]
      else
        carry_in[i] = carry_pulse && (pos_r[i-1].pending                              // [RULE9]
                      || (carry_in[i-1] && pos_r[i-1].digit == DIGIT_NINE));          // [RULE13]
    end
  end

  // ==========================================================
  // wheel motion per position
  // ==========================================================
  always_comb
  begin
    for (int i = 0; i < NPOS; i++)
    begin
      pos_nxt[i] = pos_r[i];
      // new machine cycle re-arms both starts
      if (angle_r == ANGLE_LAST)
      begin
        pos_nxt[i].add_done   = 1'b0;
        pos_nxt[i].carry_done = 1'b0;
      end
      // start taken: mesh after the engage delay
      if (add_fire[i])
      begin
        pos_nxt[i].dly      = ENGAGE_DLY - 4'h1;                                      // [RULE2]
        pos_nxt[i].add_done = 1'b1;
      end
      else if (carry_in[i] && !pos_r[i].carry_done && !pos_r[i].engaged)
      begin
        pos_nxt[i].dly        = ENGAGE_DLY - 4'h1;                                    // [RULE9]
        pos_nxt[i].carry_done = 1'b1;                                                 // [RULE16]
      end
      else if (pos_r[i].dly != 4'h0)
      begin
        pos_nxt[i].dly = pos_r[i].dly - 4'h1;
        if (pos_r[i].dly == 4'h1)
          pos_nxt[i].engaged = 1'b1;                                                  // [RULE2]
      end
      // late in the cycle the pending latch is released; done before the
      // turning step so that a wrap on the same edge would still win
      if (angle_r == PEND_CLEAR)
        pos_nxt[i].pending = 1'b0;                                                    // [RULE11]
      // turning: one unit for every 18 degrees
      if (pos_r[i].engaged)
      begin
        if (pos_r[i].sub == SUB_LAST)
        begin
          pos_nxt[i].sub = 5'h00;
          if (pos_r[i].digit == DIGIT_NINE)
          begin
            pos_nxt[i].digit   = 4'h0;                                                // [RULE6]
            pos_nxt[i].pending = 1'b1;                                                // [RULE7]
          end
          else
            pos_nxt[i].digit = pos_r[i].digit + 4'h1;                                 // [RULE4]
        end
        else
          pos_nxt[i].sub = pos_r[i].sub + 5'h01;
        // fixed stop points: first lobe for add, second for carry
        if (angle_r == ADD_STOP - 9'h001 || angle_r == CARRY_STOP - 9'h001)
        begin
          pos_nxt[i].engaged = 1'b0;                                                  // [RULE3] [RULE10]
          pos_nxt[i].sub     = 5'h00;
        end
      end
      nine_nxt[i] = (pos_nxt[i].digit == DIGIT_NINE);                                 // [RULE12]
    end
  end

  // register wheel state; a detented wheel simply keeps pos_r.digit
  always_ff @(posedge sys_clk_i)
  begin
    for (int i = 0; i < NPOS; i++)
    begin
      if (!rstn_i)
        pos_r[i] <= '0;
      else
        pos_r[i] <= pos_nxt[i];                                                       // [RULE5]
    end
    if (!rstn_i)
      nine_r <= '0;
    else
      nine_r <= nine_nxt;
  end

  // ==========================================================
  // outputs, all straight from flops
  // ==========================================================
  always_comb
  begin
    angle_o                = angle_r;
    cycle_timing_contact_o = cont_r.cycle_timing;
    carry_window_contact_o = cont_r.carry_window;
    nine_o                 = nine_r;
    for (int i = 0; i < NPOS; i++)
    begin
      digit_o[i]         = pos_r[i].digit;
      carry_pending_o[i] = pos_r[i].pending;
      engaged_o[i]       = pos_r[i].engaged;
    end
  end

  // ==========================================================
  // assertions (positions 0..1 form the first group, 8..11 a group of four)
  // ==========================================================
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  AST_ANGLE_WRAP: assert property (angle_r == ANGLE_LAST |=> angle_r == 9'h000) // [RULE15]
    else $error("angle did not wrap after 359");
  AST_SENSE_ANGLE: assert property (add_fire[0] |-> sense_angle(angle_r)) // [RULE1]
    else $error("add start outside a sensing angle");
  AST_ENGAGE_12: assert property (add_fire[0] |-> !pos_r[0].engaged ##12 pos_r[0].engaged) // [RULE2]
    else $error("wheel not meshed 12 degrees after start");
  AST_ADD_STOP: assert property (angle_r == ADD_STOP |-> engaged_o == '0) // [RULE3]
    else $error("wheel still turning at 183");
  AST_HOLD: assert property (!pos_r[0].engaged |=> $stable(pos_r[0].digit)) // [RULE5]
    else $error("disengaged digit moved");
  AST_MOD10: assert property (pos_r[1].digit <= DIGIT_NINE) // [RULE6]
    else $error("digit above nine");
  AST_WRAP_PEND: assert property (pos_r[0].engaged && pos_r[0].digit == DIGIT_NINE
      && pos_r[0].sub == SUB_LAST |=> pos_r[0].pending) // [RULE7]
    else $error("wrap did not latch pending");
  AST_CARRY_225: assert property (carry_in[1] |-> angle_r == CARRY_PULSE && $past(pos_r[0].pending, 1)) // [RULE8]
    else $error("carry outside 225 or without pending");
  AST_CARRY_UNIT: assert property (carry_in[1] && !pos_r[1].engaged
      |-> ##12 pos_r[1].engaged ##18 !pos_r[1].engaged) // [RULE10]
    else $error("carry advance not exactly one unit");
  AST_PEND_CLR: assert property (angle_r == PEND_CLEAR |=> carry_pending_o == '0) // [RULE11]
    else $error("pending not cleared");
  AST_PARALLEL: assert property (carry_in[9] && pos_r[9].digit == DIGIT_NINE |-> carry_in[10]) // [RULE13]
    else $error("carry not passed through nine");
  AST_GROUP_EDGE: assert property (carry_in[2] == 1'b0) // [RULE14]
    else $error("carry crossed group boundary");

  COV_ADD: cover property (add_fire[0] ##12 pos_r[0].engaged);
  COV_CARRY: cover property (carry_in[1]);
  COV_RUN_NINES: cover property (carry_in[9] && pos_r[9].digit == DIGIT_NINE);

endmodule : decimal_accumulator_add_carry

/* card_reader_model.sv */
// partner model: reading brushes that close through card holes at sensing angles
`timescale 1ns/1ps
module card_reader_model
  import dacc_pkg::*;
#(
  parameter int NPOS = 12                        // brushes fitted
) (
  // timing seen from the accumulator
  input  wire logic [ANGLE_W-1:0]     angle_i,
  input  wire logic                   contact_i,
  // punched value per column, 0 means no hole
  input  wire logic [NPOS-1:0][3:0]   card_i,
  // brush contact per column
  output logic      [NPOS-1:0]        hole_o
);
  // ==========================================================
  // brush contact
  // ==========================================================
  // a brush only conducts while the timing contact feeds it and its hole is
  // under it; otherwise the line rests low, like an open brush
  always_comb
  begin
    for (int i = 0; i < NPOS; i++)
    begin
      hole_o[i] = contact_i && (card_i[i] != 4'h0) &&
                  (int'(angle_i) == 9 + 18 * (9 - int'(card_i[i])));
    end
  end
endmodule : card_reader_model

/* decimal_accumulator_add_carry_tb_top.sv */
// testbench: add, carry, parallel carry through nines and group edges
`timescale 1ns/1ps
module decimal_accumulator_add_carry_tb_top;
  import dacc_pkg::*;
  // ==========================================================
  // signals
  // ==========================================================
  localparam int NP = 12;                        // small build, five groups
  logic               sys_clk_i = 1'b0;          // one edge per degree
  logic               rstn_i = 1'b0;             // held low at start
  logic [NP-1:0]      hole_i;                    // from brush model
  logic [8:0]         angle_o;                   // machine angle
  logic               ct_o;                      // sensing contact
  logic               cw_o;                      // carry window contact
  logic [NP-1:0][3:0] digit_o;                   // wheel digits
  logic [NP-1:0]      nine_o;                    // nine indications
  logic [NP-1:0]      pend_o;                    // carry pending flags
  logic [NP-1:0]      eng_o;                     // clutch engaged
  logic [NP-1:0][3:0] card = '0;                 // card under the brushes
  int                 bad_count = 0;             // mismatches
  int                 check_count = 0;           // comparisons
  int                 cycles = 0;                // timeout counter
  always #5 sys_clk_i = ~sys_clk_i;              // 100 MHz
  // ==========================================================
  // instances
  // ==========================================================
  decimal_accumulator_add_carry #(.NPOS(NP)) decimal_accumulator_add_carry_inst (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .hole_i(hole_i), .angle_o(angle_o),
    .cycle_timing_contact_o(ct_o), .carry_window_contact_o(cw_o),
    .digit_o(digit_o), .nine_o(nine_o), .carry_pending_o(pend_o), .engaged_o(eng_o));
  card_reader_model #(.NPOS(NP)) card_reader_model_inst (
    .angle_i(angle_o), .contact_i(ct_o), .card_i(card), .hole_o(hole_i));
  // ==========================================================
  // helpers
  // ==========================================================
  task automatic chk(input string name, input logic [8:0] seen, input logic [8:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // settle inside the cycle where the angle shows a; bounded by 400 degrees, just over one turn
  task automatic at(input int a);
    for (int n = 0; n < 400; n++)
    begin
      @(posedge sys_clk_i);
      #1;
      if (int'(angle_o) == a) break;
    end
  endtask : at
  // present a card from angle 1 on; it stays until the caller clears or replaces it
  task automatic feed(input logic [NP-1:0][3:0] c);
    at(1);
    card <= c;
  endtask : feed
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  // ==========================================================
  // scenarios
  // ==========================================================
  // 4 then 8 into the units: wrap to 2, carry one unit into tens
  task automatic test_carry;
    logic [NP-1:0][3:0] c;
    c = '0;
    c[0] = 4'h4;
    feed(c);
    at(183);
    chk("digit0", 9'(digit_o[0]), 9'h004);
    chk("pend0", 9'(pend_o[0]), 9'h000);
    c[0] = 4'h8;
    feed(c);
    at(27);
    chk("ct27", 9'(ct_o), 9'h001);
    at(38);
    chk("eng0 early", 9'(eng_o[0]), 9'h000);
    chk("ct38", 9'(ct_o), 9'h000);
    at(39);
    chk("eng0", 9'(eng_o[0]), 9'h001);
    at(182);
    chk("eng0 run", 9'(eng_o[0]), 9'h001);
    at(183);
    card <= '0;
    chk("eng0 stop", 9'(eng_o[0]), 9'h000);
    chk("digit0 wrap", 9'(digit_o[0]), 9'h002);
    chk("pend0 set", 9'(pend_o[0]), 9'h001);
    at(218);
    chk("cw218", 9'(cw_o), 9'h000);
    at(219);
    chk("cw219", 9'(cw_o), 9'h001);
    at(236);
    chk("cw236", 9'(cw_o), 9'h000);
    chk("eng1 early", 9'(eng_o[1]), 9'h000);
    at(237);
    chk("eng1", 9'(eng_o[1]), 9'h001);
    at(256);
    chk("digit1", 9'(digit_o[1]), 9'h001);
    chk("eng1 stop", 9'(eng_o[1]), 9'h000);
    at(257);
    chk("pend0 clr", 9'(pend_o[0]), 9'h000);
    chk("digit0 hold", 9'(digit_o[0]), 9'h002);
    $display("test_carry done");
  endtask : test_carry
  // carry through a standing nine, and no carry across a group top
  task automatic test_parallel;
    logic [NP-1:0][3:0] c;
    c = '0;
    c[8] = 4'h8;
    c[9] = 4'h9;
    c[3] = 4'h9;
    feed(c);
    at(200);
    chk("nine9", 9'(nine_o[9]), 9'h001);
    chk("nine8", 9'(nine_o[8]), 9'h000);
    c = '0;
    c[8] = 4'h3;
    c[3] = 4'h1;
    feed(c);
    at(183);
    card <= '0;
    at(237);
    chk("eng9", 9'(eng_o[9]), 9'h001);
    chk("eng10", 9'(eng_o[10]), 9'h001);
    chk("eng4", 9'(eng_o[4]), 9'h000);
    at(256);
    chk("digit8", 9'(digit_o[8]), 9'h001);
    chk("digit9", 9'(digit_o[9]), 9'h000);
    chk("digit10", 9'(digit_o[10]), 9'h001);
    chk("digit3", 9'(digit_o[3]), 9'h000);
    chk("digit4", 9'(digit_o[4]), 9'h000);
    $display("test_parallel done");
  endtask : test_parallel
  // reset in mid-cycle clears everything, counter restarts from 0
  task automatic test_reset;
    at(100);
    rstn_i <= 1'b0;
    @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    #1;
    chk("angle rst", angle_o, 9'h000);
    chk("digit1 rst", 9'(digit_o[1]), 9'h000);
    @(posedge sys_clk_i);
    #1;
    chk("angle step", angle_o, 9'h001);
    $display("test_reset done");
  endtask : test_reset
  // ==========================================================
  // main sequence and timeout
  // ==========================================================
  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (2) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    #1;
    chk("angle in rst", angle_o, 9'h000);
    test_carry();
    test_parallel();
    test_reset();
    tally_and_finish();
  end
endmodule : decimal_accumulator_add_carry_tb_top
